/* rtl/t16cf_map.vh */
`ifndef T16CF_MAP_VH
`define T16CF_MAP_VH
// ==========================================
// register indices, byte address is index*4
`define T16CF_IDX_FORCE1 8'h42
`define T16CF_IDX_PINOE 8'h66
`define T16CF_IDX_SELLO 8'h67
`define T16CF_IDX_SELHI 8'h68
`define T16CF_IDX_FORCE2 8'hc8
`define T16CF_IDX_CTRLA 8'h80
`define T16CF_IDX_CTRLB 8'h81
`define T16CF_IDX_CNTLO 8'h84
`define T16CF_IDX_CNTHI 8'h85
`define T16CF_IDX_CAPLO 8'h86
`define T16CF_IDX_CAPHI 8'h87
`define T16CF_IDX_OCALO 8'h88
`define T16CF_IDX_OCAHI 8'h89
`define T16CF_IDX_OCBLO 8'h8a
`define T16CF_IDX_OCBHI 8'h8b
`define T16CF_IDX_FLAGS 8'h8c
// ==========================================
// fields and reset values
`define T16CF_B_FILT 7
`define T16CF_B_EDGE 6
`define T16CF_B_FORCEA 7
`define T16CF_B_FORCEB 6
`define T16CF_F_CAP 5
`define T16CF_F_OCB 2
`define T16CF_F_OCA 1
`define T16CF_F_OVF 0
`define T16CF_CTRLB_WMASK 8'hdf
`define T16CF_RST8 8'h00
`define T16CF_RST16 16'h0000
// ==========================================
// clock select codes
`define T16CF_CS_STOP 3'h0
`define T16CF_CS_DIV1 3'h1
`define T16CF_CS_DIV8 3'h2
`define T16CF_CS_DIV64 3'h3
`define T16CF_CS_DIV256 3'h4
`define T16CF_CS_DIV1024 3'h5
`define T16CF_CS_EXTFALL 3'h6
`define T16CF_CS_EXTRISE 3'h7
`define T16CF_PS_M8 10'h007
`define T16CF_PS_M64 10'h03f
`define T16CF_PS_M256 10'h0ff
`define T16CF_PS_M1024 10'h3ff
// ==========================================
// compare output modes and tops
`define T16CF_COM_OFF 2'h0
`define T16CF_COM_TOG 2'h1
`define T16CF_COM_CLR 2'h2
`define T16CF_COM_SET 2'h3
`define T16CF_TOP8 16'h00ff
`define T16CF_TOP9 16'h01ff
`define T16CF_TOP10 16'h03ff
`define T16CF_TOPMAX 16'hffff
`define T16CF_WGM_NORMAL 4'h0
`define T16CF_WGM_CTCA 4'h4
`define T16CF_WGM_CTCI 4'hc
`define T16CF_FILT_ONES 4'hf
`define T16CF_FILT_ZERO 4'h0
`define T16CF_RESP_OKAY 2'h0
`define T16CF_RESP_SLVERR 2'h2
`endif

/* rtl/t16cf_timer.v */
// Notes on behaviour
// - filter needs four equal samples to change
// - edge select bit: zero falling, one rising
// - capture copies counter and sets capture flag
// - capture disabled when capture register is top
// - clock select picks stop, taps or pin
// - pin edges count even when pin outputs
// - force1 bits act only in non-PWM modes, force2 strobes in any mode
// - force strobe applies match to output now
// - force raises no flag, never clears counter
// - force bits always read zero
// - two-bit route select per pin, A/B alternate
// - pin enable drives output regardless of mode
// - counter bytes through shared high latch
// - counter write blocks next timer clock match
// - compare registers compared continuously with counter
// - compare writes go through shared latch
// - non-PWM modes: off, toggle, clear, set
// - capture flag clears on ack or one
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "t16cf_map.vh"
module t16cf_timer (
  input wire clk_sys,
  input wire reset,
  input wire [9:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [9:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire capturePin,
  input wire extCountPin,
  input wire captureAck,
  input wire timer0CmpA,
  input wire timer0CmpB,
  input wire timer2CmpA,
  input wire timer2CmpB,
  output wire compareOutA,
  output wire compareOutB,
  output wire forceMatch2A,
  output wire forceMatch2B,
  output wire captureFlag,
  output wire [7:0] routedPin,
  output wire [7:0] routedPinOe
);

// ==========================================
// functions
function isPwm;
  input [3:0] wgm;
  begin
    isPwm = !(wgm == `T16CF_WGM_NORMAL || wgm == `T16CF_WGM_CTCA ||
      wgm == `T16CF_WGM_CTCI);
  end
endfunction

function icrIsTop;
  input [3:0] wgm;
  begin
    icrIsTop = wgm[3] && !wgm[0] && wgm != 4'h0;
  end
endfunction

function [15:0] topOf;
  input [3:0] wgm;
  input [15:0] ocra;
  input [15:0] icr;
  begin
    case (wgm[1:0])
      2'h1: topOf = `T16CF_TOP8;
      2'h2: topOf = `T16CF_TOP9;
      2'h3: topOf = `T16CF_TOP10;
      default: topOf = `T16CF_TOPMAX;
    endcase
    if (wgm == `T16CF_WGM_CTCA || (wgm[3] && wgm[0]))
      topOf = ocra;
    else if (icrIsTop(wgm))
      topOf = icr;
  end
endfunction

function comNext;
  input [1:0] com;
  input cur;
  begin
    case (com)
      `T16CF_COM_TOG: comNext = !cur;
      `T16CF_COM_CLR: comNext = 1'b0;
      `T16CF_COM_SET: comNext = 1'b1;
      default: comNext = cur;
    endcase
  end
endfunction

function pickOut;
  input [1:0] sel;
  input t0;
  input t1;
  input t2;
  begin
    if (sel[1])
      pickOut = t2;
    else if (sel[0])
      pickOut = t1;
    else
      pickOut = t0;
  end
endfunction

// ==========================================
// registers
reg awHeld_r, wHeld_r, bvalid_r, rvalid_r;
reg [7:0] awIdx_r;
reg [31:0] wData_r;
reg [3:0] wStrb_r;
reg [1:0] bresp_r, rresp_r;
reg [31:0] rdata_r;
reg [7:0] ctrlA_r, ctrlB_r, pinOe_r, selLo_r, selHi_r, temp_r;
reg [15:0] cnt_r, ocrA_r, ocrB_r, cap_r;
reg capF_r, ocaF_r, ocbF_r, ovF_r, block_r, ocA_r, ocB_r;
reg force2A_r, force2B_r;
reg [9:0] presc_r;
reg [2:0] extS_r, capS_r;
reg extLvl_r, extPrev_r, capLvl_r, capFilt_r, capPrev_r;
reg [3:0] filt_r;
reg [7:0] routed_r;
reg [7:0] rdByte;
reg rdOk;
reg tick;
integer i;

wire [3:0] wgm = {ctrlB_r[4:3], ctrlA_r[1:0]};
wire [2:0] clkSel = ctrlB_r[2:0];
wire pwm = isPwm(wgm);
wire [15:0] top = topOf(wgm, ocrA_r, cap_r);
wire [15:0] routeSel = {selHi_r, selLo_r};
wire doWrite = awHeld_r && wHeld_r;
wire wrEn = doWrite && wStrb_r[0];
wire [7:0] wrByte = wData_r[7:0];
wire [7:0] arIdx = s_axi_araddr[9:2];
wire rdTake = s_axi_arvalid && !rvalid_r;
// same set of indices as the read decode, so a write never answers okay where a read fails
wire wrOk = awIdx_r == `T16CF_IDX_FORCE1 || awIdx_r == `T16CF_IDX_FORCE2 ||
  awIdx_r == `T16CF_IDX_PINOE || awIdx_r == `T16CF_IDX_SELLO ||
  awIdx_r == `T16CF_IDX_SELHI || awIdx_r == `T16CF_IDX_CTRLA || awIdx_r == `T16CF_IDX_CTRLB ||
  (awIdx_r >= `T16CF_IDX_CNTLO && awIdx_r <= `T16CF_IDX_FLAGS);

// ==========================================
// bus handshake
assign s_axi_awready = !awHeld_r && !bvalid_r;
assign s_axi_wready = !wHeld_r && !bvalid_r;
assign s_axi_bvalid = bvalid_r;
assign s_axi_bresp = bresp_r;
assign s_axi_arready = !rvalid_r;
assign s_axi_rvalid = rvalid_r;
assign s_axi_rdata = rdata_r;
assign s_axi_rresp = rresp_r;

always @(posedge clk_sys) begin
  if (reset) begin
    {awHeld_r, wHeld_r, bvalid_r, rvalid_r} <= 4'h0;
    awIdx_r <= `T16CF_RST8;
    {wData_r, rdata_r} <= 64'h0;
    wStrb_r <= 4'h0;
    {bresp_r, rresp_r} <= {2{`T16CF_RESP_OKAY}};
  end else begin
    if (s_axi_awvalid && s_axi_awready) begin
      awHeld_r <= 1'b1;
      awIdx_r <= s_axi_awaddr[9:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wHeld_r <= 1'b1;
      wData_r <= s_axi_wdata;
      wStrb_r <= s_axi_wstrb;
    end
    if (doWrite) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      bvalid_r <= 1'b1;
      bresp_r <= wrOk ? `T16CF_RESP_OKAY : `T16CF_RESP_SLVERR;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
    if (rdTake) begin
      rvalid_r <= 1'b1;
      rdata_r <= {24'h0, rdByte};
      rresp_r <= rdOk ? `T16CF_RESP_OKAY : `T16CF_RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end
end

// ==========================================
// read decode
always @* begin
  rdByte = `T16CF_RST8;
  rdOk = 1'b1;
  case (arIdx)
    `T16CF_IDX_FORCE1: rdByte = `T16CF_RST8;
    `T16CF_IDX_FORCE2: rdByte = `T16CF_RST8;
    `T16CF_IDX_PINOE: rdByte = pinOe_r;
    `T16CF_IDX_SELLO: rdByte = selLo_r;
    `T16CF_IDX_SELHI: rdByte = selHi_r;
    `T16CF_IDX_CTRLA: rdByte = ctrlA_r;
    `T16CF_IDX_CTRLB: rdByte = ctrlB_r;
    `T16CF_IDX_CNTLO: rdByte = cnt_r[7:0];
    `T16CF_IDX_CNTHI: rdByte = temp_r;
    `T16CF_IDX_CAPLO: rdByte = cap_r[7:0];
    `T16CF_IDX_CAPHI: rdByte = temp_r;
    `T16CF_IDX_OCALO: rdByte = ocrA_r[7:0];
    `T16CF_IDX_OCAHI: rdByte = ocrA_r[15:8];
    `T16CF_IDX_OCBLO: rdByte = ocrB_r[7:0];
    `T16CF_IDX_OCBHI: rdByte = ocrB_r[15:8];
    `T16CF_IDX_FLAGS: rdByte = {2'h0, capF_r, 2'h0, ocbF_r, ocaF_r, ovF_r};
    default: rdOk = 1'b0;
  endcase
end

// ==========================================
// clock source
always @* begin
  case (clkSel)
    `T16CF_CS_DIV1: tick = 1'b1;
    `T16CF_CS_DIV8: tick = (presc_r & `T16CF_PS_M8) == `T16CF_PS_M8;
    `T16CF_CS_DIV64: tick = (presc_r & `T16CF_PS_M64) == `T16CF_PS_M64;
    `T16CF_CS_DIV256: tick = (presc_r & `T16CF_PS_M256) == `T16CF_PS_M256;
    `T16CF_CS_DIV1024: tick = presc_r == `T16CF_PS_M1024;
    // pin is sampled whatever its direction
    `T16CF_CS_EXTFALL: tick = extPrev_r && !extLvl_r;
    `T16CF_CS_EXTRISE: tick = !extPrev_r && extLvl_r;
    default: tick = 1'b0;
  endcase
end

// ==========================================
// pin sampling
// prescaler free runs, so the first tap tick lands anywhere in its period
always @(posedge clk_sys) begin
  if (reset) begin
    presc_r <= 10'h0;
    extS_r <= 3'h0;
    capS_r <= 3'h0;
    {extLvl_r, extPrev_r, capLvl_r, capFilt_r, capPrev_r} <= 5'h00;
    filt_r <= `T16CF_FILT_ZERO;
  end else begin
    presc_r <= presc_r + 10'h1;
    extS_r <= {extS_r[1:0], extCountPin};
    capS_r <= {capS_r[1:0], capturePin};
    if (extS_r[1] == extS_r[2])
      extLvl_r <= extS_r[2];
    if (capS_r[1] == capS_r[2])
      capLvl_r <= capS_r[2];
    extPrev_r <= extLvl_r;
    filt_r <= {filt_r[2:0], capLvl_r};
    if (filt_r == `T16CF_FILT_ONES)
      capFilt_r <= 1'b1;
    else if (filt_r == `T16CF_FILT_ZERO)
      capFilt_r <= 1'b0;
    capPrev_r <= ctrlB_r[`T16CF_B_FILT] ? capFilt_r : capLvl_r;
  end
end

wire capNow = ctrlB_r[`T16CF_B_FILT] ? capFilt_r : capLvl_r;
wire capEdge = ctrlB_r[`T16CF_B_EDGE] ? (capNow && !capPrev_r) :
  (!capNow && capPrev_r);
wire capEvent = capEdge && !icrIsTop(wgm);
wire atTop = tick && cnt_r == top;
wire cntWr = wrEn && awIdx_r == `T16CF_IDX_CNTLO;
wire matchA = tick && cnt_r == ocrA_r && !block_r;
wire matchB = tick && cnt_r == ocrB_r && !block_r;
wire forceA = wrEn && awIdx_r == `T16CF_IDX_FORCE1 && wrByte[`T16CF_B_FORCEA] && !pwm;
wire forceB = wrEn && awIdx_r == `T16CF_IDX_FORCE1 && wrByte[`T16CF_B_FORCEB] && !pwm;
wire flagClr = wrEn && awIdx_r == `T16CF_IDX_FLAGS;

// ==========================================
// registers, counter, compare and capture
always @(posedge clk_sys) begin
  if (reset) begin
    {ctrlA_r, ctrlB_r, pinOe_r, selLo_r, selHi_r, temp_r} <= {6{`T16CF_RST8}};
    {cnt_r, ocrA_r, ocrB_r, cap_r} <= {4{`T16CF_RST16}};
    {capF_r, ocaF_r, ocbF_r, ovF_r, block_r, ocA_r, ocB_r} <= 7'h00;
    {force2A_r, force2B_r} <= 2'h0;
  end else begin
    force2A_r <= 1'b0;
    force2B_r <= 1'b0;
    // low read snapshots the high byte for the paired high read
    if (rdTake && arIdx == `T16CF_IDX_CNTLO)
      temp_r <= cnt_r[15:8];
    if (rdTake && arIdx == `T16CF_IDX_CAPLO)
      temp_r <= cap_r[15:8];
    if (wrEn) begin
      case (awIdx_r)
        `T16CF_IDX_PINOE: pinOe_r <= wrByte;
        `T16CF_IDX_SELLO: selLo_r <= wrByte;
        `T16CF_IDX_SELHI: selHi_r <= wrByte;
        `T16CF_IDX_CTRLA: ctrlA_r <= wrByte;
        `T16CF_IDX_CTRLB: ctrlB_r <= wrByte & `T16CF_CTRLB_WMASK;
        `T16CF_IDX_CNTHI: temp_r <= wrByte;
        `T16CF_IDX_CAPHI: temp_r <= wrByte;
        `T16CF_IDX_OCAHI: temp_r <= wrByte;
        `T16CF_IDX_OCBHI: temp_r <= wrByte;
        `T16CF_IDX_CAPLO: cap_r <= {temp_r, wrByte};
        `T16CF_IDX_OCALO: ocrA_r <= {temp_r, wrByte};
        `T16CF_IDX_OCBLO: ocrB_r <= {temp_r, wrByte};
        `T16CF_IDX_FORCE2: begin
          force2A_r <= wrByte[`T16CF_B_FORCEA];
          force2B_r <= wrByte[`T16CF_B_FORCEB];
        end
        default: ;
      endcase
    end
    // counter write wins over counting; match blocked for one tick
    if (cntWr) begin
      cnt_r <= {temp_r, wrByte};
      block_r <= 1'b1;
    end else if (tick) begin
      block_r <= 1'b0;
      cnt_r <= (cnt_r == top) ? `T16CF_RST16 : cnt_r + 16'h1;
    end
    if (capEvent)
      cap_r <= cnt_r;
    // hardware set beats the clear in the same cycle
    if (capEvent || (atTop && icrIsTop(wgm)))
      capF_r <= 1'b1;
    else if (captureAck || (flagClr && wrByte[`T16CF_F_CAP]))
      capF_r <= 1'b0;
    // forced strobes never reach the flags
    if (matchA)
      ocaF_r <= 1'b1;
    else if (flagClr && wrByte[`T16CF_F_OCA])
      ocaF_r <= 1'b0;
    if (matchB)
      ocbF_r <= 1'b1;
    else if (flagClr && wrByte[`T16CF_F_OCB])
      ocbF_r <= 1'b0;
    if (atTop)
      ovF_r <= 1'b1;
    else if (flagClr && wrByte[`T16CF_F_OVF])
      ovF_r <= 1'b0;
    // waveform: non-PWM applies mode on match or strobe
    if (!pwm) begin
      if (matchA || forceA)
        ocA_r <= comNext(ctrlA_r[7:6], ocA_r);
      if (matchB || forceB)
        ocB_r <= comNext(ctrlA_r[5:4], ocB_r);
    end else begin
      // pwm simplified to single slope: match then restore at wrap
      if (matchA && ctrlA_r[7])
        ocA_r <= ctrlA_r[6];
      else if (atTop && ctrlA_r[7])
        ocA_r <= !ctrlA_r[6];
      if (matchB && ctrlA_r[5])
        ocB_r <= ctrlA_r[4];
      else if (atTop && ctrlA_r[5])
        ocB_r <= !ctrlA_r[4];
    end
  end
end

// ==========================================
// output pin routing
always @(posedge clk_sys) begin
  if (reset) begin
    routed_r <= `T16CF_RST8;
  end else begin
    for (i = 0; i < 8; i = i + 1) begin
      if (i % 2 == 0)
        routed_r[i] <= pickOut(routeSel[2 * i +: 2], timer0CmpB, ocB_r, timer2CmpB);
      else
        routed_r[i] <= pickOut(routeSel[2 * i +: 2], timer0CmpA, ocA_r, timer2CmpA);
    end
  end
end

assign routedPin = routed_r;
assign routedPinOe = pinOe_r;
assign compareOutA = ocA_r;
assign compareOutB = ocB_r;
assign forceMatch2A = force2A_r;
assign forceMatch2B = force2B_r;
assign captureFlag = capF_r;

endmodule

/* tb/t16cf_cpu_model.sv */
`timescale 1ns/1ns
// ==========================================
// cpu side master, one access at a time
module t16cf_cpu_model (
  input wire clk_sys,
  output logic [9:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  output logic s_axi_bready,
  output logic [9:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  output logic s_axi_rready
);
  // slow: request offered one cycle later; answer ready always high from the start
  logic slow = 1'b0;
  initial begin
    s_axi_awaddr = 10'h000;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_araddr = 10'h000;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b1;
  end
  task automatic wr(input [7:0] i, input [7:0] d, output [1:0] r);
    if (slow) @(posedge clk_sys);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      // stale data must not look valid once taken
      if (s_axi_wvalid && s_axi_wready) s_axi_wdata <= ~s_axi_wdata;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    r = s_axi_bresp;
  endtask
  task automatic rd(input [7:0] i, output [7:0] d, output [1:0] r);
    if (slow) @(posedge clk_sys);
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready));
    d = s_axi_rdata[7:0];
    r = s_axi_rresp;
  endtask
endmodule

/* tb/t16cf_tb_top.sv */
`timescale 1ns/1ns
`include "t16cf_map.vh"
`define CHK(a, b) begin \
  checks++; \
  if ((a) !== (b)) begin \
    mismatches++; \
    $display("BAD %0t %h %h", $time, (a), (b)); \
  end \
end
module tb_top;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [9:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, s2;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic capturePin = 1'b0, extCountPin = 1'b0, captureAck = 1'b0;
  logic timer0CmpA = 1'b0, timer0CmpB = 1'b0, timer2CmpA = 1'b0, timer2CmpB = 1'b0;
  logic compareOutA, compareOutB, forceMatch2A, forceMatch2B, captureFlag;
  logic [7:0] routedPin, routedPinOe, d8, sl, sh, ex;
  logic [15:0] cnt, lo;
  logic la = 1'b0, lb = 1'b0;
  logic [1:0] cm [5] = '{2'h3, 2'h0, 2'h2, 2'h1, 2'h1};
  logic [7:0] ri [5] = '{`T16CF_IDX_FORCE1, `T16CF_IDX_PINOE, `T16CF_IDX_SELLO,
    `T16CF_IDX_SELHI, `T16CF_IDX_FORCE2};
  int dv [5] = '{1, 8, 64, 256, 1024};
  int checks = 0, mismatches = 0, seed = 92;
  t16cf_timer dut (.*);
  t16cf_cpu_model cpu (.*);
  initial forever #5 clk_sys = ~clk_sys;
  // ==========================================
  // access helpers
  function automatic logic map(input [7:0] i);
    return i inside {`T16CF_IDX_FORCE1, `T16CF_IDX_PINOE, `T16CF_IDX_SELLO, `T16CF_IDX_SELHI,
      `T16CF_IDX_FORCE2, `T16CF_IDX_CTRLA, `T16CF_IDX_CTRLB,
      [`T16CF_IDX_CNTLO:`T16CF_IDX_FLAGS]};
  endfunction
  task automatic w(input [7:0] i, input [7:0] d);
    logic [1:0] r;
    cpu.wr(i, d, r);
    `CHK(r, map(i) ? `T16CF_RESP_OKAY : `T16CF_RESP_SLVERR)
  endtask
  task automatic rc(input [7:0] i, input [7:0] e);
    logic [7:0] d;
    logic [1:0] r;
    cpu.rd(i, d, r);
    `CHK({r, d}, {map(i) ? `T16CF_RESP_OKAY : `T16CF_RESP_SLVERR, e})
  endtask
  task automatic rcnt(output logic [15:0] c);
    logic [1:0] r;
    cpu.rd(`T16CF_IDX_CNTLO, c[7:0], r);
    cpu.rd(`T16CF_IDX_CNTHI, c[15:8], r);
  endtask
  // pin high for n cycles then low; flag looked at both times
  task automatic cp(input [7:0] b, input int n, input logic m, input logic f);
    w(`T16CF_IDX_CTRLB, b);
    capturePin <= 1'b1;
    repeat (n) @(posedge clk_sys);
    `CHK(captureFlag, m)
    capturePin <= 1'b0;
    repeat (12) @(posedge clk_sys);
    `CHK(captureFlag, f)
  endtask
  task automatic test_done;
    if (mismatches == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #400000;
    mismatches++;
    test_done;
  end
  // ==========================================
  // main sequence
  initial begin
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    foreach (ri[k]) rc(ri[k], `T16CF_RST8);
    for (int k = 1; k < 4; k++) begin
      cpu.slow = k[1];
      d8 = 8'($random(seed));
      w(ri[k], d8);
      rc(ri[k], d8);
    end
    cpu.slow = 1'b0;
    // one high byte shared by compare a, compare b and counter
    w(`T16CF_IDX_OCAHI, 8'h12);
    w(`T16CF_IDX_OCALO, 8'h34);
    w(`T16CF_IDX_OCBLO, 8'h56);
    w(`T16CF_IDX_CNTLO, 8'h05);
    rc(`T16CF_IDX_OCBHI, 8'h12);
    rc(`T16CF_IDX_OCALO, 8'h34);
    w(`T16CF_IDX_CTRLB, 8'h08);
    foreach (cm[k]) begin
      w(`T16CF_IDX_CTRLA, {cm[k], cm[k], 4'h0});
      w(`T16CF_IDX_FORCE1, 8'hc0);
      la = cm[k] == `T16CF_COM_TOG ? !la : cm[k][1] ? cm[k][0] : la;
      lb = cm[k] == `T16CF_COM_TOG ? !lb : cm[k][1] ? cm[k][0] : lb;
      repeat (2) @(posedge clk_sys);
      `CHK({compareOutA, compareOutB}, {la, lb})
    end
    w(`T16CF_IDX_FORCE2, 8'hc0);
    rc(`T16CF_IDX_FORCE1, 8'h00);
    rc(`T16CF_IDX_FLAGS, 8'h00);
    rc(`T16CF_IDX_CNTLO, 8'h05);
    rc(`T16CF_IDX_CNTHI, 8'h12);
    w(`T16CF_IDX_CTRLB, 8'h00);
    w(`T16CF_IDX_CTRLA, 8'hf1);
    w(`T16CF_IDX_FORCE1, 8'hc0);
    repeat (2) @(posedge clk_sys);
    `CHK({compareOutA, compareOutB}, {la, lb})
    w(`T16CF_IDX_CTRLA, 8'h00);
    foreach (dv[k]) begin
      w(`T16CF_IDX_CNTHI, 8'h00);
      w(`T16CF_IDX_CNTLO, 8'h00);
      w(`T16CF_IDX_CTRLB, 8'(k + 1));
      repeat (2048) @(posedge clk_sys);
      w(`T16CF_IDX_CTRLB, 8'h00);
      rcnt(cnt);
      lo = 16'(2048 / dv[k]);
      `CHK(cnt >= lo && cnt <= lo + 16'd8, 1'b1)
    end
    for (int m = 6; m < 8; m++) begin
      w(`T16CF_IDX_CNTLO, 8'h00);
      w(`T16CF_IDX_CTRLB, 8'(m));
      repeat (5) begin
        extCountPin <= 1'b1;
        repeat (4) @(posedge clk_sys);
        extCountPin <= 1'b0;
        repeat (4) @(posedge clk_sys);
      end
      repeat (8) @(posedge clk_sys);
      w(`T16CF_IDX_CTRLB, 8'h00);
      rcnt(cnt);
      `CHK(cnt, 16'h0005)
    end
    w(`T16CF_IDX_CNTHI, 8'h0a);
    w(`T16CF_IDX_CNTLO, 8'hbc);
    cp(8'h40, 12, 1'b1, 1'b1);
    rc(`T16CF_IDX_CAPLO, 8'hbc);
    rc(`T16CF_IDX_CAPHI, 8'h0a);
    captureAck <= 1'b1;
    @(posedge clk_sys);
    captureAck <= 1'b0;
    repeat (2) @(posedge clk_sys);
    `CHK(captureFlag, 1'b0)
    cp(8'h00, 12, 1'b0, 1'b1);
    w(`T16CF_IDX_FLAGS, 8'h20);
    @(posedge clk_sys);
    `CHK(captureFlag, 1'b0)
    cp(8'hc0, 3, 1'b0, 1'b0);
    cp(8'hc0, 12, 1'b1, 1'b1);
    w(`T16CF_IDX_FLAGS, 8'h20);
    w(`T16CF_IDX_CNTLO, 8'h00);
    cp(8'h58, 12, 1'b0, 1'b0);
    rc(`T16CF_IDX_CAPLO, 8'hbc);
    w(`T16CF_IDX_CTRLB, 8'h00);
    repeat (4) begin
      sl = 8'($random(seed));
      sh = 8'($random(seed));
      {timer0CmpA, timer0CmpB, timer2CmpA, timer2CmpB} <= 4'($random(seed));
      w(`T16CF_IDX_SELLO, sl);
      w(`T16CF_IDX_SELHI, sh);
      repeat (2) @(posedge clk_sys);
      for (int p = 0; p < 8; p++) begin
        s2 = 2'({sh, sl} >> (2 * p));
        ex[p] = p[0] ? (s2[1] ? timer2CmpA : s2[0] ? la : timer0CmpA)
          : (s2[1] ? timer2CmpB : s2[0] ? lb : timer0CmpB);
      end
      `CHK(routedPin, ex)
    end
    // counter loaded onto compare a must skip that match, then match when it counts past
    w(`T16CF_IDX_OCAHI, 8'h00);
    w(`T16CF_IDX_OCALO, 8'h10);
    w(`T16CF_IDX_CNTLO, 8'h10);
    w(`T16CF_IDX_CTRLA, 8'h40);
    w(`T16CF_IDX_CTRLB, 8'h01);
    w(`T16CF_IDX_CTRLB, 8'h00);
    rc(`T16CF_IDX_FLAGS, 8'h00);
    `CHK(compareOutA, la)
    w(`T16CF_IDX_CNTLO, 8'h00);
    w(`T16CF_IDX_CTRLB, 8'h01);
    repeat (32) @(posedge clk_sys);
    w(`T16CF_IDX_CTRLB, 8'h00);
    la = !la;
    rc(`T16CF_IDX_FLAGS, 8'h02);
    `CHK(compareOutA, la)
    w(8'h90, 8'h55);
    rc(8'h90, 8'h00);
    test_done;
  end
endmodule

/* tb/t16cf_timer_asserts.sv */
`timescale 1ns/1ns
`include "t16cf_map.vh"
// ==========================================
// bus timing and strobe checks
module t16cf_timer_asserts (
  input wire clk_sys,
  input wire reset,
  input wire [9:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire forceMatch2A,
  input wire forceMatch2B,
  input wire [7:0] routedPinOe
);
  // last taken address and data, so effects can be tied to their cause
  logic [7:0] awIdx_r = 8'h00;
  logic [8:0] wDat_r = 9'h000;
  always @(posedge clk_sys) begin
    if (s_axi_awvalid && s_axi_awready) awIdx_r <= s_axi_awaddr[9:2];
    if (s_axi_wvalid && s_axi_wready) wDat_r <= {s_axi_wstrb[0], s_axi_wdata[7:0]};
  end
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  a_wr_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_wr_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_wr_block: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during answer");
  a_rd_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000)
    else $error("read answer wrong");
  a_rd_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_rd_block: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during answer");
  a_force_a: assert property (
    $rose(s_axi_bvalid) && awIdx_r == `T16CF_IDX_FORCE2 && wDat_r[8]
    |-> forceMatch2A == wDat_r[7] ##1 !forceMatch2A)
    else $error("force a strobe wrong");
  a_force_b: assert property (
    $rose(s_axi_bvalid) && awIdx_r == `T16CF_IDX_FORCE2 && wDat_r[8]
    |-> forceMatch2B == wDat_r[6] ##1 !forceMatch2B)
    else $error("force b strobe wrong");
  a_force_cause: assert property (
    forceMatch2A || forceMatch2B |-> $rose(s_axi_bvalid) && awIdx_r == `T16CF_IDX_FORCE2)
    else $error("force strobe without write");
  a_oe_write: assert property (
    $rose(s_axi_bvalid) && awIdx_r == `T16CF_IDX_PINOE && wDat_r[8]
    |-> routedPinOe == wDat_r[7:0])
    else $error("pin enable not written");
  a_oe_hold: assert property (
    !$rose(s_axi_bvalid) |-> $stable(routedPinOe))
    else $error("pin enable moved");
endmodule
bind t16cf_timer t16cf_timer_asserts chk (.*);
